// >>> design/cms_sequencer.sv
// cycle sequencer for multiply, single load/store and block load
// How it works
// - request and sequential hint are issued one cycle ahead of their cycle
// - first multiply cycle passes accumulator or zero into the result
// - first multiply cycle loads multiplier into Booth shifter and prefetches PC+8
// - later multiply cycles add, subtract or keep the multiplicand per Booth
// - iteration N uses multiplicand shifted by 2N or 2N+1
// - multiplier shifts right two bits; stop at zero, one more for borrow
// - multiply cycles after the first are internal; fetch PC+12 after M+1
// - multiply into the counter writes nothing to it
// - load cycle one computes address while prefetching PC+8
// - load cycle two reads data and updates base
// - load cycle three writes destination without a memory request
// - load that writes the counter refetches new address and plus four
// - aborted load read blocks base and destination writes
// - byte/word and translation only in single transfer cycle; else word
// - store writes data and base in cycle two; no third cycle unless the written-back base is the counter, which adds two refill cycles
// - store changes counter only as written-back base; abort blocks write-back
// - block load: address in cycle one, first word and base in two
// - later block cycles write previous word, fetch next, hold base latch
// - final cycle writes last word to its register; internal only for a one-register list, else it reads PC+12
// - abort in block load blocks later writes; final cycle restores base
// - block load with counter as base suppresses write-back
// - counter in list loads last and refills; abort leaves it unchanged
`timescale 1ns/10ps
`default_nettype none
module cms_sequencer (
	input wire logic clk,
	input wire logic srst,
	input wire logic start,
	input wire cms_pkg::cms_op_type opKind,
	input wire logic [31:0] pcIn,
	input wire logic [31:0] operandA,
	input wire logic [31:0] operandB,
	input wire logic [31:0] accumIn,
	input wire logic [31:0] baseIn,
	input wire logic [31:0] offsetIn,
	input wire logic offsetUp,
	input wire logic preIndex,
	input wire logic writeBack,
	input wire logic byteOp,
	input wire logic forceTrans,
	input wire logic [3:0] baseReg,
	input wire logic [3:0] destReg,
	input wire logic [15:0] regList,
	input wire logic [31:0] readData,
	input wire logic dataAbort,
	output logic busy,
	output logic [31:0] address,
	output logic memory_request_n,
	output logic next_cycle_follows,
	output logic writeCycle,
	output logic wordAccess,
	output logic instruction_fetch_n,
	output logic translate_n,
	output logic [31:0] writeData,
	output logic regWrite,
	output logic [3:0] regWriteAddr,
	output logic [31:0] regWriteData,
	output logic [31:0] productOut,
	output logic [31:0] baseLatch,
	output logic pipeFlush
);
	// ****************************************
	// state
	// ****************************************
	cms_pkg::cms_state_type state_q;
	cms_pkg::cms_op_type op_q;
	logic [31:0] pc_q, mcand_q, mplier_q, result_q, xferAddr_q, newBase_q, newPc_q;
	logic [31:0] held_q;
	logic [3:0] base_q, dest_q, heldReg_q;
	logic [15:0] list_q;
	logic [4:0] iter_q;
	logic borrow_q, wb_q, aborted_q, held_q_valid, pcLoad_q, pcWb_q, firstWord_q;
	logic [3:0] listIdx;
	logic listLast;
	logic [31:0] offsetAddr, booth2N, boothTerm;
	logic [1:0] boothBits;
	logic [32:0] boothRecode;
	logic mulDone;

	// lowest set register of the remaining list; counter is bit 15 so it goes last
	always_comb begin
		listIdx = 4'h0;
		for (int i = 15; i >= 0; i--) begin
			if (list_q[i]) begin
				listIdx = 4'(i);
			end
		end
	end
	assign listLast = ((list_q & (list_q - 16'h0001)) == 16'h0000);
	assign offsetAddr = offsetUp ? baseIn + offsetIn : baseIn - offsetIn;

	// ****************************************
	// booth recoding
	// ****************************************
	assign boothRecode = {mplier_q, borrow_q};
	assign boothBits = boothRecode[2:1];
	// done once shifter empties with no borrow left
	assign mulDone = ((mplier_q >> cms_pkg::BOOTH_SHIFT) == 32'h00000000) && !boothRecode[2];
	assign booth2N = mcand_q << {iter_q, 1'b0};
	always_comb begin
		boothTerm = 32'h00000000;
		unique case ({boothRecode[2:0]})
			3'h1, 3'h2: boothTerm = booth2N;
			3'h3: boothTerm = booth2N << 1;
			3'h4: boothTerm = -(booth2N << 1);
			3'h5, 3'h6: boothTerm = -booth2N;
			default: boothTerm = 32'h00000000;
		endcase
	end

	// ****************************************
	// sequence
	// ****************************************
	always_ff @(posedge clk) begin
		if (srst) begin
			state_q <= cms_pkg::ST_IDLE;
			op_q <= cms_pkg::OP_NONE;
			pc_q <= cms_pkg::RESET_PC;
			mcand_q <= 32'h00000000;
			mplier_q <= 32'h00000000;
			result_q <= 32'h00000000;
			xferAddr_q <= 32'h00000000;
			newBase_q <= 32'h00000000;
			newPc_q <= 32'h00000000;
			held_q <= 32'h00000000;
			base_q <= 4'h0;
			dest_q <= 4'h0;
			heldReg_q <= 4'h0;
			list_q <= 16'h0000;
			iter_q <= 5'h00;
			borrow_q <= 1'b0;
			wb_q <= 1'b0;
			aborted_q <= 1'b0;
			held_q_valid <= 1'b0;
			pcLoad_q <= 1'b0;
			pcWb_q <= 1'b0;
			firstWord_q <= 1'b0;
		end else begin
			unique case (state_q)
				cms_pkg::ST_IDLE: begin
					if (start && opKind != cms_pkg::OP_NONE) begin
						state_q <= cms_pkg::ST_FIRST;
						op_q <= opKind;
						pc_q <= pcIn;
						aborted_q <= 1'b0;
						held_q_valid <= 1'b0;
						pcLoad_q <= 1'b0;
						pcWb_q <= 1'b0;
						iter_q <= 5'h00;
						borrow_q <= 1'b0;
						base_q <= baseReg;
						dest_q <= destReg;
						list_q <= regList;
						wb_q <= writeBack && !(opKind == cms_pkg::OP_LDM && baseReg == cms_pkg::PC_REG);
						mplier_q <= operandA;
						mcand_q <= operandB;
						result_q <= (opKind == cms_pkg::OP_MLA) ? accumIn : 32'h00000000;
						xferAddr_q <= preIndex ? offsetAddr : baseIn;
						newBase_q <= offsetAddr;
					end
				end
				cms_pkg::ST_FIRST: begin
					if (op_q == cms_pkg::OP_MUL || op_q == cms_pkg::OP_MLA) begin
						state_q <= cms_pkg::ST_MULT;
					end else if (op_q == cms_pkg::OP_LDM) begin
						state_q <= cms_pkg::ST_BLOCK;
						firstWord_q <= 1'b1;
					end else begin
						state_q <= cms_pkg::ST_XFER;
					end
				end
				cms_pkg::ST_MULT: begin
					result_q <= result_q + boothTerm;
					mplier_q <= mplier_q >> cms_pkg::BOOTH_SHIFT;
					borrow_q <= boothRecode[2];
					iter_q <= iter_q + 5'h01;
					if ((mplier_q >> cms_pkg::BOOTH_SHIFT) == 32'h00000000
						&& !boothRecode[2]) begin
						state_q <= cms_pkg::ST_IDLE;
					end
				end
				cms_pkg::ST_XFER: begin
					aborted_q <= dataAbort;
					held_q <= readData;
					if (!dataAbort && wb_q && base_q == cms_pkg::PC_REG) begin
						pcWb_q <= 1'b1;
						newPc_q <= newBase_q;
					end
					if (op_q == cms_pkg::OP_LDR) begin
						state_q <= cms_pkg::ST_FINAL;
						if (!dataAbort && dest_q == cms_pkg::PC_REG) begin
							pcLoad_q <= 1'b1;
							newPc_q <= readData;
						end
					end else begin
						state_q <= (!dataAbort && wb_q && base_q == cms_pkg::PC_REG)
							? cms_pkg::ST_REFILL1 : cms_pkg::ST_IDLE;
					end
				end
				cms_pkg::ST_BLOCK: begin
					firstWord_q <= 1'b0;
					aborted_q <= aborted_q | dataAbort;
					held_q <= readData;
					heldReg_q <= listIdx;
					held_q_valid <= 1'b1;
					xferAddr_q <= xferAddr_q + cms_pkg::OFS_WORD;
					list_q <= list_q & ~(16'h0001 << listIdx);
					if (listIdx == cms_pkg::PC_REG && !(aborted_q | dataAbort)) begin
						pcLoad_q <= 1'b1;
						newPc_q <= readData;
					end
					if (listLast) begin
						state_q <= cms_pkg::ST_FINAL;
					end
				end
				cms_pkg::ST_FINAL: begin
					held_q_valid <= 1'b0;
					if (!aborted_q && (pcLoad_q || pcWb_q)) begin
						state_q <= cms_pkg::ST_REFILL1;
					end else begin
						state_q <= cms_pkg::ST_IDLE;
					end
				end
				cms_pkg::ST_REFILL1: begin
					state_q <= cms_pkg::ST_REFILL2;
				end
				cms_pkg::ST_REFILL2: begin
					state_q <= cms_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// ****************************************
	// bus outputs, registered
	// ****************************************
	always_ff @(posedge clk) begin
		if (srst) begin
			busy <= 1'b0;
			address <= cms_pkg::RESET_PC;
			memory_request_n <= 1'b1;
			next_cycle_follows <= 1'b0;
			writeCycle <= 1'b0;
			wordAccess <= 1'b1;
			instruction_fetch_n <= 1'b1;
			translate_n <= 1'b1;
			writeData <= 32'h00000000;
		end else begin
			busy <= (state_q != cms_pkg::ST_IDLE) || start;
			wordAccess <= 1'b1;
			translate_n <= 1'b1;
			writeCycle <= 1'b0;
			instruction_fetch_n <= 1'b1;
			memory_request_n <= 1'b1;
			next_cycle_follows <= 1'b0;
			unique case (state_q)
				cms_pkg::ST_IDLE: begin
					if (start && opKind != cms_pkg::OP_NONE) begin
						address <= pcIn + cms_pkg::OFS_PC8;
						instruction_fetch_n <= 1'b0;
						memory_request_n <= (opKind == cms_pkg::OP_MUL
							|| opKind == cms_pkg::OP_MLA) ? 1'b1 : 1'b0;
					end
				end
				cms_pkg::ST_FIRST: begin
					if (op_q == cms_pkg::OP_MUL || op_q == cms_pkg::OP_MLA) begin
						address <= pc_q + cms_pkg::OFS_PC12;
						memory_request_n <= 1'b1;
					end else begin
						address <= xferAddr_q;
						wordAccess <= (op_q == cms_pkg::OP_LDM) ? 1'b1 : !byteOp;
						translate_n <= (op_q == cms_pkg::OP_LDM) ? 1'b1 : !forceTrans;
						writeCycle <= (op_q == cms_pkg::OP_STR);
						writeData <= operandA;
						memory_request_n <= (op_q == cms_pkg::OP_STR) ? 1'b0 : 1'b1;
						next_cycle_follows <= (op_q == cms_pkg::OP_LDM) && !listLast;
						memory_request_n <= (op_q == cms_pkg::OP_STR
							|| (op_q == cms_pkg::OP_LDM && !listLast)) ? 1'b0 : 1'b1;
					end
				end
				cms_pkg::ST_MULT: begin
					address <= pc_q + cms_pkg::OFS_PC12;
					if ((mplier_q >> cms_pkg::BOOTH_SHIFT) == 32'h00000000
						&& !boothRecode[2]) begin
						memory_request_n <= 1'b0;
						next_cycle_follows <= 1'b1;
					end
				end
				cms_pkg::ST_XFER, cms_pkg::ST_BLOCK: begin
					if (state_q == cms_pkg::ST_BLOCK && !listLast) begin
						address <= xferAddr_q + cms_pkg::OFS_WORD;
						memory_request_n <= 1'b0;
						next_cycle_follows <= 1'b1;
					end else if (state_q == cms_pkg::ST_XFER && op_q == cms_pkg::OP_STR) begin
						address <= (!dataAbort && wb_q && base_q == cms_pkg::PC_REG)
							? newBase_q : pc_q + cms_pkg::OFS_PC12;
						memory_request_n <= 1'b0;
						instruction_fetch_n <= 1'b0;
					end else begin
						address <= pc_q + cms_pkg::OFS_PC12;
						memory_request_n <= 1'b0;
						next_cycle_follows <= 1'b1;
					end
				end
				cms_pkg::ST_FINAL: begin
					address <= (!aborted_q && (pcLoad_q || pcWb_q)) ? newPc_q
						: pc_q + cms_pkg::OFS_PC12;
					instruction_fetch_n <= 1'b0;
					memory_request_n <= 1'b0;
					next_cycle_follows <= 1'b1;
				end
				cms_pkg::ST_REFILL1: begin
					address <= newPc_q + cms_pkg::OFS_WORD;
					instruction_fetch_n <= 1'b0;
					memory_request_n <= 1'b0;
					next_cycle_follows <= 1'b1;
				end
				cms_pkg::ST_REFILL2: begin
					address <= newPc_q + cms_pkg::OFS_PC8;
				end
			endcase
		end
	end

	// ****************************************
	// register file writes
	// ****************************************
	always_ff @(posedge clk) begin
		if (srst) begin
			regWrite <= 1'b0;
			regWriteAddr <= 4'h0;
			regWriteData <= 32'h00000000;
			productOut <= 32'h00000000;
			baseLatch <= 32'h00000000;
			pipeFlush <= 1'b0;
		end else begin
			regWrite <= 1'b0;
			pipeFlush <= 1'b0;
			unique case (state_q)
				cms_pkg::ST_MULT: begin
					productOut <= result_q + boothTerm;
					// no counter write
					// partial sums stay internal; only the final sum is written
					regWrite <= (dest_q != cms_pkg::PC_REG) && mulDone;
					regWriteAddr <= dest_q;
					regWriteData <= result_q + boothTerm;
				end
				cms_pkg::ST_XFER: begin
					regWrite <= wb_q && !dataAbort;
					regWriteAddr <= base_q;
					regWriteData <= newBase_q;
				end
				cms_pkg::ST_BLOCK: begin
					if (firstWord_q) begin
						regWrite <= wb_q && !dataAbort;
						regWriteAddr <= base_q;
						regWriteData <= newBase_q;
					end else begin
						regWrite <= held_q_valid && !aborted_q && heldReg_q != cms_pkg::PC_REG;
						regWriteAddr <= heldReg_q;
						regWriteData <= held_q;
					end
					baseLatch <= newBase_q;
				end
				cms_pkg::ST_FINAL: begin
					if (op_q == cms_pkg::OP_LDM && aborted_q) begin
						regWrite <= wb_q;
						regWriteAddr <= base_q;
						regWriteData <= baseLatch;
					end else begin
						regWrite <= !aborted_q && ((op_q == cms_pkg::OP_LDR) ? 1'b1
							: heldReg_q != cms_pkg::PC_REG);
						regWriteAddr <= (op_q == cms_pkg::OP_LDR) ? dest_q : heldReg_q;
						regWriteData <= held_q;
						pipeFlush <= !aborted_q && (pcLoad_q || pcWb_q);
					end
				end
				default: begin
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// >>> pkg/cms_pkg.sv
// constants and types for the memory cycle sequencer
package cms_pkg;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 32;
	localparam int REG_W = 4;
	localparam int LIST_W = 16;
	localparam logic [3:0] PC_REG = 4'hF;
	localparam logic [ADDR_W-1:0] OFS_PC8 = 32'h00000008;
	localparam logic [ADDR_W-1:0] OFS_PC12 = 32'h0000000C;
	localparam logic [ADDR_W-1:0] OFS_WORD = 32'h00000004;
	localparam logic [1:0] BOOTH_SHIFT = 2'h2;
	localparam logic [ADDR_W-1:0] RESET_PC = 32'h00000000;
	typedef enum logic [2:0] {
		OP_NONE,
		OP_MUL,
		OP_MLA,
		OP_LDR,
		OP_STR,
		OP_LDM
	} cms_op_type;
	typedef enum {
		ST_IDLE,
		ST_FIRST,
		ST_MULT,
		ST_XFER,
		ST_BLOCK,
		ST_FINAL,
		ST_REFILL1,
		ST_REFILL2
	} cms_state_type;
endpackage

// >>> testbench/cms_sequencer_assertions.sv
// checker for the memory cycle sequencer
`timescale 1ns/10ps
`default_nettype none
module cms_sequencer_checker (
	input wire logic clk,
	input wire logic srst,
	input wire logic start,
	input wire cms_pkg::cms_op_type opKind,
	input wire logic [31:0] pcIn,
	input wire logic [31:0] operandA,
	input wire logic [31:0] baseIn,
	input wire logic [31:0] offsetIn,
	input wire logic offsetUp,
	input wire logic preIndex,
	input wire logic writeBack,
	input wire logic byteOp,
	input wire logic forceTrans,
	input wire logic [3:0] baseReg,
	input wire logic [3:0] destReg,
	input wire logic dataAbort,
	input wire logic busy,
	input wire logic [31:0] address,
	input wire logic memory_request_n,
	input wire logic next_cycle_follows,
	input wire logic writeCycle,
	input wire logic wordAccess,
	input wire logic instruction_fetch_n,
	input wire logic translate_n,
	input wire logic [31:0] writeData,
	input wire logic regWrite,
	input wire logic [3:0] regWriteAddr,
	input wire logic pipeFlush
);
	// ****
	// helper state
	// ****
	logic take, isMul, isXfer;
	logic [7:0] cyc_q;
	cms_pkg::cms_op_type op_q;
	logic [31:0] pc_q, xfer_q, data_q;
	logic byte_q, force_q, norm_q, abort_q;
	assign take = !busy && start && opKind != cms_pkg::OP_NONE;
	assign isMul = op_q == cms_pkg::OP_MUL || op_q == cms_pkg::OP_MLA;
	assign isXfer = (op_q == cms_pkg::OP_LDR || op_q == cms_pkg::OP_STR) && cyc_q == 8'h02;
	// counter runs free after a start, so an early busy drop cannot freeze it
	always_ff @(posedge clk) begin
		if (srst) begin
			cyc_q <= 8'h00;
			op_q <= cms_pkg::OP_NONE;
			abort_q <= 1'b0;
		end else if (take) begin
			cyc_q <= 8'h01;
			op_q <= opKind;
			abort_q <= 1'b0;
			pc_q <= pcIn;
			xfer_q <= preIndex ? (offsetUp ? baseIn + offsetIn : baseIn - offsetIn) : baseIn;
			data_q <= operandA;
			byte_q <= byteOp;
			force_q <= forceTrans;
			norm_q <= destReg != cms_pkg::PC_REG && !(baseReg == cms_pkg::PC_REG && writeBack);
		end else begin
			cyc_q <= (cyc_q == 8'hFF) ? cyc_q : cyc_q + 8'h01;
			abort_q <= abort_q || (op_q == cms_pkg::OP_LDM && cyc_q >= 8'h02 && dataAbort);
		end
	end
	// ****
	// properties
	// ****
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	AST_RESET_STATE:
	assert property (disable iff (1'b0) srst |=> !busy && memory_request_n && wordAccess && translate_n)
		else $error("outputs not idle after reset");
	AST_FIRST_FETCH:
	assert property (take |=> address == $past(pcIn) + cms_pkg::OFS_PC8 && !instruction_fetch_n)
		else $error("first cycle is not a fetch of pc plus 8");
	AST_MUL_FIRST:
	assert property (isMul && cyc_q == 8'h01 |-> memory_request_n)
		else $error("multiply requests memory for its second cycle");
	AST_MUL_INTERNAL:
	assert property (isMul && busy && cyc_q > 8'h01 |->
		instruction_fetch_n && !writeCycle && address == pc_q + cms_pkg::OFS_PC12)
		else $error("multiply cycle is not internal at pc plus 12");
	AST_MUL_NO_PC:
	assert property (isMul && regWrite |-> regWriteAddr != cms_pkg::PC_REG)
		else $error("multiply wrote the counter");
	AST_XFER:
	assert property (isXfer |-> address == xfer_q && wordAccess == !byte_q && translate_n == !force_q)
		else $error("transfer cycle address or size wrong");
	AST_WORD_ELSE:
	assert property (!isXfer |-> wordAccess && translate_n)
		else $error("byte or translation outside transfer cycle");
	AST_STORE_DATA:
	assert property (isXfer && op_q == cms_pkg::OP_STR |-> writeCycle && writeData == data_q ##1 !writeCycle)
		else $error("store write cycle wrong");
	AST_LDR_INTERNAL:
	assert property (op_q == cms_pkg::OP_LDR && norm_q && cyc_q == 8'h03 |->
		instruction_fetch_n && $past(memory_request_n) && !memory_request_n && next_cycle_follows)
		else $error("load third cycle not internal and sequential");
	AST_LDR_ABORT:
	assert property (op_q == cms_pkg::OP_LDR && cyc_q == 8'h02 && dataAbort |=> !regWrite [*3])
		else $error("aborted load wrote a register");
	AST_LDM_FLUSH:
	assert property (op_q == cms_pkg::OP_LDM && abort_q |-> !pipeFlush)
		else $error("aborted block load changed the counter");
endmodule
bind cms_sequencer cms_sequencer_checker cms_sequencer_checker_inst (.clk, .srst, .start, .opKind,
	.pcIn, .operandA, .baseIn, .offsetIn, .offsetUp, .preIndex, .writeBack, .byteOp, .forceTrans,
	.baseReg, .destReg, .dataAbort, .busy, .address, .memory_request_n, .next_cycle_follows,
	.writeCycle, .wordAccess, .instruction_fetch_n, .translate_n, .writeData, .regWrite,
	.regWriteAddr, .pipeFlush);
`default_nettype wire

// >>> testbench/cms_memory_model.sv
// memory system model facing the sequencer
`timescale 1ns/10ps
`default_nettype none
module cms_memory_model (
	input wire logic clk,
	input wire logic [31:0] address,
	input wire logic memory_request_n,
	input wire logic writeCycle,
	input wire logic abortOn,
	input wire logic [31:0] abortAddr,
	output logic [31:0] readData,
	output logic dataAbort
);
	logic req_q = 1'b0;
	initial readData = 32'h00000000;
	initial dataAbort = 1'b0;
	always @(posedge clk) req_q <= !memory_request_n;
	// idle bus inverts data every cycle, so a stale value does not match on the next cycle but returns after two idle cycles
	always @(negedge clk) begin
		readData <= (req_q && !writeCycle) ? {address[15:0], ~address[15:0]} : ~readData;
		dataAbort <= req_q && abortOn && address == abortAddr;
	end
endmodule
`default_nettype wire

// >>> testbench/cms_sequencer_tb_top.sv
// self-checking bench for the memory cycle sequencer
`timescale 1ns/10ps
`default_nettype none
module cms_sequencer_tb_top;
	logic clk = 1'b0, srst = 1'b1, start = 1'b0, offsetUp = 1'b1, preIndex = 1'b1;
	logic writeBack = 1'b0, byteOp = 1'b0, forceTrans = 1'b0, abortOn = 1'b0, quiet = 1'b0;
	cms_pkg::cms_op_type opKind = cms_pkg::OP_NONE;
	logic [31:0] pcIn = 32'h0, operandA = 32'h0, operandB = 32'h0, accumIn = 32'h0;
	logic [31:0] baseIn = 32'h0, offsetIn = 32'h0, abortAddr = 32'h0;
	logic [3:0] baseReg = 4'h0, destReg = 4'h0;
	logic [15:0] regList = 16'h0;
	logic [31:0] readData, address, writeData, regWriteData, productOut, baseLatch;
	logic dataAbort, busy, memory_request_n, next_cycle_follows, writeCycle, wordAccess;
	logic instruction_fetch_n, translate_n, regWrite, pipeFlush;
	logic [3:0] regWriteAddr;
	logic [35:0] expQ [$];
	int fail_count = 0, checks_done = 0, flushes = 0, efl = 0;
	cms_sequencer cms_sequencer_inst (.clk, .srst, .start, .opKind, .pcIn, .operandA, .operandB,
		.accumIn, .baseIn, .offsetIn, .offsetUp, .preIndex, .writeBack, .byteOp, .forceTrans,
		.baseReg, .destReg, .regList, .readData, .dataAbort, .busy, .address, .memory_request_n,
		.next_cycle_follows, .writeCycle, .wordAccess, .instruction_fetch_n, .translate_n,
		.writeData, .regWrite, .regWriteAddr, .regWriteData, .productOut, .baseLatch, .pipeFlush);
	cms_memory_model cms_memory_model_inst (.clk, .address, .memory_request_n, .writeCycle,
		.abortOn, .abortAddr, .readData, .dataAbort);
	always #50 clk = ~clk;
	// ****
	// checking
	// ****
	task compare(input logic [35:0] exp, input logic [35:0] got);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED at %0t: expected %h got %h", $time, exp, got);
		end
	endtask
	always @(posedge clk) begin
		if (regWrite === 1'b1 && !quiet)
			compare(expQ.size() ? expQ.pop_front() : 'x, {regWriteAddr, regWriteData});
		if (pipeFlush === 1'b1)
			flushes++;
	end
	task wrap_up;
		$display("checks %0d failures %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task go(input cms_pkg::cms_op_type op, input string name);
		int n;
		@(negedge clk);
		opKind = op;
		start = 1'b1;
		@(negedge clk);
		start = 1'b0;
		n = 0;
		while (busy !== 1'b0 && n < 200) begin
			@(negedge clk);
			n++;
		end
		repeat (4) @(negedge clk);
		compare(36'h0, 36'(expQ.size()));
		$display("test %s done", name);
	endtask
	// ****
	// scenarios
	// ****
	initial begin
		logic [31:0] x;
		int idx;
		void'($urandom(32'h56e7cb96));
		repeat (5) @(negedge clk);
		srst = 1'b0;
		for (int i = 0; i < 12; i++) begin
			operandA = (i == 3) ? 32'hFFFFFFFF : (i < 3) ? 32'(i) : $urandom;
			operandB = $urandom;
			accumIn = $urandom;
			pcIn = $urandom & 32'hFFFFFFFC;
			destReg = (i == 5) ? cms_pkg::PC_REG : 4'($urandom_range(14, 0));
			x = operandA * operandB + (i[0] ? accumIn : 32'h0);
			if (destReg != cms_pkg::PC_REG)
				expQ.push_back({destReg, x});
			go(i[0] ? cms_pkg::OP_MLA : cms_pkg::OP_MUL, "multiply");
			compare({4'h0, x}, {4'h0, productOut});
		end
		for (int i = 0; i < 10; i++) begin
			baseIn = $urandom & 32'hFFFFFFFC;
			offsetIn = 32'($urandom_range(63, 0)) << 2;
			offsetUp = 1'($urandom);
			writeBack = i[0] || i > 7;
			byteOp = (i > 4) ? 1'($urandom) : 1'b0;
			forceTrans = 1'($urandom);
			operandA = $urandom;
			baseReg = 4'($urandom_range(6, 0));
			destReg = baseReg + 4'h7;
			x = offsetUp ? baseIn + offsetIn : baseIn - offsetIn;
			abortOn = i == 4 || i == 9;
			abortAddr = x;
			if (writeBack && !abortOn)
				expQ.push_back({baseReg, x});
			if (i < 4)
				expQ.push_back({destReg, x[15:0], ~x[15:0]});
			go((i < 5) ? cms_pkg::OP_LDR : cms_pkg::OP_STR, (i < 5) ? "load" : "store");
		end
		preIndex = 1'b0;
		offsetUp = 1'b1;
		writeBack = 1'b1;
		byteOp = 1'b0;
		for (int i = 0; i < 5; i++) begin
			baseIn = $urandom & 32'hFFFFFFFC;
			baseReg = (i == 3) ? cms_pkg::PC_REG : 4'h0;
			regList = (16'($urandom) & 16'h7FFE) | 16'h0006 | ((i > 2) ? 16'h8000 : 16'h0000);
			abortOn = i == 4;
			abortAddr = baseIn + 32'h4;
			quiet = i == 4;
			efl += (i == 3);
			idx = 0;
			for (int k = 1; k < 16; k++)
				idx += regList[k];
			offsetIn = 32'(idx) * 4;
			if (i < 3)
				expQ.push_back({4'h0, baseIn + 32'(idx) * 4});
			idx = 0;
			for (int k = 1; k < 15; k++) begin
				if (regList[k] && i < 4) begin
					x = baseIn + 32'(idx) * 4;
					expQ.push_back({4'(k), x[15:0], ~x[15:0]});
					idx++;
				end
			end
			go(cms_pkg::OP_LDM, "block load");
			quiet = 1'b0;
		end
		compare(36'(efl), 36'(flushes));
		wrap_up();
	end
	// span of 10000 cycles is some twenty times the expected run of about 500 cycles
	initial begin
		#1000000;
		fail_count++;
		wrap_up();
	end
endmodule
`default_nettype wire
